// *** logic/tpc_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
// for the PWM / carrier timer. Included by the top and the testbench.
//
// How it works
// [R1] Software keeps remote-mode bit while running
// [R2] Same-value carrier control refresh is harmless
// [R3] Duty change reaches compare after three ticks
// [R4] Software rewrites duty compare after every restart
// [R5] PWM duty below period, both 00H..FFH
// [R6] Level buffer moves to active level
// [R7] Partner event interrupt only in carrier mode
// [R8] Timer clock above six times partner clock
// [R9] Carrier period and duty within 01H..FFH
// [R10] Restart loads written duty before first cycle
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ***************************************************************
// Word offsets on the register bus
// ***************************************************************
`define TPC_OFS_MODE     3'h0
`define TPC_OFS_PERIOD   3'h1
`define TPC_OFS_DUTY     3'h2
`define TPC_OFS_CARRIER  3'h3
`define TPC_OFS_STATUS   3'h4
`define TPC_OFS_MASK     3'h5
`define TPC_OFS_COUNT    3'h6

// ***************************************************************
// Field positions
// ***************************************************************
`define TPC_MODE_RUN     0
`define TPC_MODE_CKS_LO  1
`define TPC_MODE_CKS_HI  3
`define TPC_MODE_CARR    4
`define TPC_CAR_BUF      0
`define TPC_CAR_ACT      1
`define TPC_CAR_RMT      7
`define TPC_ST_PERIOD    0
`define TPC_ST_DUTY      1
`define TPC_ST_PARTNER   2

// ***************************************************************
// Reset values and timing counts
// ***************************************************************
`define TPC_RST_MODE     8'h00
`define TPC_RST_PERIOD   8'hFF
`define TPC_RST_DUTY     8'h00
`define TPC_RST_CARRIER  8'h00
`define TPC_RST_MASK     3'h0
`define TPC_DUTY_DELAY   2'h3

`endif

// *** logic/tpc_pkg.sv ***
// Types shared by the PWM / carrier timer files.
// Does not include tpc_cfg.svh and needs nothing on the include path.
package tpc_pkg;
  // Output waveform modes
  typedef enum logic {TPC_MODE_PWM, TPC_MODE_CARRIER} tpc_mode_t;
  typedef logic [7:0] tpc_byte_t;
  typedef logic [2:0] tpc_evt_t;
endpackage : tpc_pkg

// *** logic/tpc_prescale.sv ***
// Count clock prescaler: one tick every 2**sel core clocks.
// Assumes a single clock domain; restarts whenever run is low.
`timescale 1ns/1ps
module tpc_prescale
  import tpc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [6:0] div_r;
  logic [6:0] div_nxt;

  // Ones in the low sel bits
  function automatic logic [6:0] tpc_mask(input logic [2:0] s);
    tpc_mask = 7'((8'h01 << s) - 8'h01);
  endfunction : tpc_mask

  // Divider next value
  always_comb begin
    div_nxt = run ? 7'(div_r + 7'h01) : 7'h00;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Tick when all low bits are set
  assign tick = run & ((div_r & tpc_mask(sel)) == tpc_mask(sel));

endmodule : tpc_prescale

// *** logic/tpc_top.sv ***
// PWM / carrier timer with an Avalon-MM register slave.
// Assumes one 100 MHz core clock, partner event from a foreign domain.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_top
  import tpc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        partner_evt,
  output logic             timer_out,
  output logic             irq
);

  // ***************************************************************
  // Register bus slave
  // ***************************************************************
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        bus_wr;
  logic [7:0]  wbyte;

  // Core state
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  period_r, period_nxt;
  logic [7:0]  duty_buf_r, duty_buf_nxt;
  logic [7:0]  duty_act_r, duty_act_nxt;
  logic        pend_r, pend_nxt;
  logic [1:0]  pend_cnt_r, pend_cnt_nxt;
  logic [7:0]  carrier_r, carrier_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        run_d_r, run_d_nxt;
  tpc_evt_t    status_r, status_nxt;
  tpc_evt_t    mask_r, mask_nxt;
  logic        out_r, out_nxt;
  logic        irq_r, irq_nxt;
  logic [2:0]  sync_r, sync_nxt;
  logic        evt_lvl_r, evt_lvl_nxt;

  logic        run;
  logic        tick;
  logic        evt_rise;
  tpc_mode_t   mode;
  tpc_evt_t    events;
  logic        wave;
  logic        duty_wr;

  assign bus_wr = avs_write & ~wait_r;
  assign wbyte  = avs_writedata[7:0];
  assign run    = mode_r[`TPC_MODE_RUN];
  assign mode   = tpc_mode_t'(mode_r[`TPC_MODE_CARR]);
  // Duty write landing this cycle, restarts the transfer count
  assign duty_wr = bus_wr & (avs_address == `TPC_OFS_DUTY);

  // Handshake and read mux: request seen, answer next cycle
  always_comb begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read | avs_write) & wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          `TPC_OFS_MODE:    rdata_nxt[7:0] = mode_r;
          `TPC_OFS_PERIOD:  rdata_nxt[7:0] = period_r;
          `TPC_OFS_DUTY:    rdata_nxt[7:0] = duty_buf_r;
          `TPC_OFS_CARRIER: rdata_nxt[7:0] = carrier_r;
          `TPC_OFS_STATUS:  rdata_nxt[2:0] = status_r;
          `TPC_OFS_MASK:    rdata_nxt[2:0] = mask_r;
          `TPC_OFS_COUNT:   rdata_nxt[7:0] = cnt_r;
          default:          rdata_nxt      = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  // ***************************************************************
  // Count clock and partner event input
  // ***************************************************************
  tpc_prescale u_prescale (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (run),
    .sel      (mode_r[`TPC_MODE_CKS_HI:`TPC_MODE_CKS_LO]),
    .tick     (tick)
  );

  // Three-stage synchroniser with agreement filter
  always_comb begin
    sync_nxt    = {sync_r[1:0], partner_evt};
    evt_lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : evt_lvl_r;
  end

  assign evt_rise = evt_lvl_nxt & ~evt_lvl_r;

  // ***************************************************************
  // Timer core
  // ***************************************************************
  // Held low in the restart cycle so a stale duty never shows
  assign wave = run & run_d_r & (cnt_r < duty_act_r); // [R10]

  always_comb begin
    mode_nxt     = mode_r;
    period_nxt   = period_r;
    duty_buf_nxt = duty_buf_r;
    duty_act_nxt = duty_act_r;
    pend_nxt     = pend_r;
    pend_cnt_nxt = pend_cnt_r;
    carrier_nxt  = carrier_r;
    cnt_nxt      = cnt_r;
    mask_nxt     = mask_r;
    run_d_nxt    = run;
    events       = 3'h0;
    // Register writes
    if (bus_wr) begin
      unique case (avs_address)
        `TPC_OFS_MODE:   mode_nxt   = wbyte;
        `TPC_OFS_PERIOD: period_nxt = wbyte;
        `TPC_OFS_DUTY: begin
          duty_buf_nxt = wbyte;
          pend_nxt     = 1'b1;                        // [R3]
          pend_cnt_nxt = 2'h0;
        end
        `TPC_OFS_CARRIER: begin
          carrier_nxt[`TPC_CAR_BUF] = wbyte[`TPC_CAR_BUF];
          if (!run) begin
            carrier_nxt[`TPC_CAR_RMT] = wbyte[`TPC_CAR_RMT];
          end                                          // [R2] [R1]
        end
        `TPC_OFS_MASK:   mask_nxt   = wbyte[2:0];
        default:         ;
      endcase
    end
    // Restart: load written duty before first output cycle
    if (run & ~run_d_r) begin
      duty_act_nxt = duty_buf_r;                       // [R10]
      pend_nxt     = 1'b0;
      cnt_nxt      = 8'h00;
    end else if (pend_r & tick) begin
      // Duty transfer after three count clock ticks
      if (pend_cnt_r == 2'(`TPC_DUTY_DELAY - 2'h1)) begin
        duty_act_nxt = duty_buf_r;                     // [R3]
        pend_nxt     = duty_wr;
      end else if (!duty_wr) begin
        pend_cnt_nxt = 2'(pend_cnt_r + 2'h1);
      end
    end
    // Counter and compare matches
    if (run & tick & ~(run & ~run_d_r)) begin
      if (cnt_r == period_r) begin
        cnt_nxt                = 8'h00;
        events[`TPC_ST_PERIOD] = 1'b1;
      end else begin
        cnt_nxt = 8'(cnt_r + 8'h01);
      end
      if (cnt_r == duty_act_r) begin
        events[`TPC_ST_DUTY] = 1'b1;
      end
    end
    if (!run) begin
      cnt_nxt = 8'h00;
    end
    // Partner event moves level buffer into active level
    if (evt_rise & (mode == TPC_MODE_CARRIER)) begin
      carrier_nxt[`TPC_CAR_ACT] = carrier_r[`TPC_CAR_BUF]; // [R6]
      events[`TPC_ST_PARTNER]   = 1'b1;                   // [R7]
    end
    // Sticky status: set wins over write-one clear
    status_nxt = status_r;
    if (bus_wr & (avs_address == `TPC_OFS_STATUS)) begin
      status_nxt = status_r & ~wbyte[2:0];
    end
    status_nxt = status_nxt | events;
    irq_nxt    = |(status_nxt & mask_nxt);
    // Output pin: carrier gated by active level in remote mode
    if (mode == TPC_MODE_PWM) begin
      out_nxt = wave;
    end else if (carrier_nxt[`TPC_CAR_RMT]) begin
      out_nxt = wave & carrier_nxt[`TPC_CAR_ACT];
    end else begin
      out_nxt = run & carrier_nxt[`TPC_CAR_ACT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r     <= `TPC_RST_MODE;
      period_r   <= `TPC_RST_PERIOD;
      duty_buf_r <= `TPC_RST_DUTY;
      duty_act_r <= `TPC_RST_DUTY;
      pend_r     <= 1'b0;
      pend_cnt_r <= 2'h0;
      carrier_r  <= `TPC_RST_CARRIER;
      cnt_r      <= 8'h00;
      run_d_r    <= 1'b0;
      status_r   <= 3'h0;
      mask_r     <= `TPC_RST_MASK;
      out_r      <= 1'b0;
      irq_r      <= 1'b0;
      sync_r     <= 3'h0;
      evt_lvl_r  <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      period_r   <= period_nxt;
      duty_buf_r <= duty_buf_nxt;
      duty_act_r <= duty_act_nxt;
      pend_r     <= pend_nxt;
      pend_cnt_r <= pend_cnt_nxt;
      carrier_r  <= carrier_nxt;
      cnt_r      <= cnt_nxt;
      run_d_r    <= run_d_nxt;
      status_r   <= status_nxt;
      mask_r     <= mask_nxt;
      out_r      <= out_nxt;
      irq_r      <= irq_nxt;
      sync_r     <= sync_nxt;
      evt_lvl_r  <= evt_lvl_nxt;
    end
  end

  assign timer_out = out_r;
  assign irq       = irq_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking tpc_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  remote_bit_hold_a: assert property (                               // [R1]
    (bus_wr && avs_address == `TPC_OFS_CARRIER && run)
      |=> $stable(carrier_r[`TPC_CAR_RMT]))
    else $error("remote bit changed while running");

  refresh_keeps_ctrl_a: assert property (                            // [R2]
    (bus_wr && avs_address == `TPC_OFS_CARRIER && run && wbyte == carrier_r && !evt_rise)
      |=> $stable(carrier_r))
    else $error("carrier refresh disturbed the control bits");

  duty_not_early_a: assert property (                                // [R3]
    (bus_wr && avs_address == `TPC_OFS_DUTY && run && run_d_r && tick)
      |=> pend_r && pend_cnt_r == 2'h0)
    else $error("duty transfer counter not restarted");

  duty_transfer_a: assert property (                                 // [R3]
    (pend_r && run && run_d_r && tick && pend_cnt_r == 2'h2)
      |=> duty_act_r == $past(duty_buf_r))
    else $error("duty not moved on third tick");

  restart_load_a: assert property (                                  // [R10]
    (run && !run_d_r) |=> (duty_act_r == $past(duty_buf_r)) && cnt_r == 8'h00)
    else $error("restart did not load duty");

  level_move_a: assert property (                                    // [R6]
    (evt_rise && mode == TPC_MODE_CARRIER)
      |=> carrier_r[`TPC_CAR_ACT] == $past(carrier_r[`TPC_CAR_BUF]))
    else $error("level buffer not transferred");

  partner_irq_a: assert property (                                   // [R7]
    (evt_rise && mode == TPC_MODE_CARRIER && mask_r[`TPC_ST_PARTNER])
      |=> status_r[`TPC_ST_PARTNER] && irq)
    else $error("partner interrupt missing");

  partner_mode_a: assert property (                                  // [R7]
    (mode == TPC_MODE_PWM && !status_r[`TPC_ST_PARTNER])
      ##1 $stable(mode_r) |-> !status_r[`TPC_ST_PARTNER])
    else $error("partner status set outside carrier mode");

  bus_answer_a: assert property (
    ((avs_read || avs_write) && wait_r) |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle");

  restart_quiet_a: assert property (                                 // [R10]
    (run && !run_d_r && mode == TPC_MODE_PWM) |=> !timer_out)
    else $error("output pulsed before duty was loaded");

  duty_cov_c:    cover property (pend_r && tick && pend_cnt_r == 2'h2);
  remote_cov_c:  cover property (run && carrier_r[`TPC_CAR_RMT] && evt_rise);
  restart_cov_c: cover property (run && !run_d_r);
  carrier_cov_c: cover property (evt_rise && mode == TPC_MODE_CARRIER);
  irq_cov_c:     cover property (!irq ##1 irq);

endmodule : tpc_top

// *** testbench/tb.sv ***
// Self-checking bench for the PWM / carrier timer top level.
// Assumes tpc_pkg is compiled first and tpc_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tb;
  import tpc_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        partner_evt;
  logic        timer_out;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  logic [31:0] rnd;
  int          n_errors;
  int          n_compared;
  int          hi;

  tpc_top tpc_top_i (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .partner_evt     (partner_evt),
    .timer_out       (timer_out),
    .irq             (irq)
  );

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  // ***************************************************************
  // Checking and closing
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Read data monitor, oldest note against each answered read
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 32'h0000_0000, 32'hFFFF_FFFF);
      end else begin
        chk("readdata", exp_q.pop_front(), avs_readdata);
      end
    end
  end

  // ***************************************************************
  // Avalon master tasks
  // ***************************************************************
  task automatic wait_ans();
    bit ok;
    ok = 0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge core_clk);
      ok = (avs_waitrequest === 1'b0);
    end
    if (!ok) begin
      $display("[FAIL] waitrequest expected 0 seen 1");
      n_errors++;
      end_sim();
    end
  endtask : wait_ans

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_write     <= 1'b1;
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    wait_ans();
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    @(posedge core_clk);
    avs_read    <= 1'b1;
    avs_address <= a;
    wait_ans();
    avs_read <= 1'b0;
  endtask : rd

  task automatic clks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : clks

  // Count cycles with the output high
  task automatic highs(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge core_clk);
      h += timer_out;
    end
  endtask : highs

  // Long partner event pulse, well below the timer clock rate
  task automatic evt();
    @(posedge core_clk);
    partner_evt <= 1'b1;
    clks(10);
    partner_evt <= 1'b0;
    clks(10);
  endtask : evt

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  logic [7:0] rst_tab [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  initial begin
    core_clk = 0; nrst = 0; avs_address = 0; avs_read = 0; avs_write = 0;
    avs_writedata = 0; partner_evt = 0; n_errors = 0; n_compared = 0;
    seed = 32'h4321;
    clks(16);
    nrst <= 1'b1;
    // Reset values, unmapped offset included
    for (int a = 0; a < 8; a++) rd(a[2:0], rst_tab[a]);
    wr(3'h7, 8'hA5);
    rd(3'h7, 8'h00);
    // Random period and duty with duty below period, timer stopped
    repeat (4) begin
      rnd = $random(seed);
      wr(`TPC_OFS_PERIOD, {1'b1, rnd[6:0]});
      wr(`TPC_OFS_DUTY, {1'b0, rnd[14:8]});
      rd(`TPC_OFS_PERIOD, {1'b1, rnd[6:0]});
      rd(`TPC_OFS_DUTY, {1'b0, rnd[14:8]});
    end
    // Duty change while counting lands on the third tick (tick every 8)
    wr(`TPC_OFS_PERIOD, 8'hFF);
    wr(`TPC_OFS_DUTY, 8'h00);
    wr(`TPC_OFS_MODE, 8'h07);
    wr(`TPC_OFS_DUTY, 8'hFF);
    clks(15);
    chk("timer_out early", 32'h0, {31'h0, timer_out});
    clks(13);
    chk("timer_out late", 32'h1, {31'h0, timer_out});
    // Restart loads the newly written duty at once
    wr(`TPC_OFS_MODE, 8'h06);
    wr(`TPC_OFS_DUTY, 8'h00);
    wr(`TPC_OFS_MODE, 8'h07);
    repeat (3) begin
      clks(1);
      chk("timer_out restart", 32'h0, {31'h0, timer_out});
    end
    // Carrier mode, remote bit set up before running
    wr(`TPC_OFS_MODE, 8'h00);
    wr(`TPC_OFS_CARRIER, 8'h00);
    wr(`TPC_OFS_PERIOD, 8'h10);
    wr(`TPC_OFS_DUTY, 8'h08);
    wr(`TPC_OFS_MODE, 8'h11);
    wr(`TPC_OFS_CARRIER, 8'h00);
    rd(`TPC_OFS_MODE, 8'h11);
    rd(`TPC_OFS_CARRIER, 8'h00);
    chk("carrier level low", 32'h0, {31'h0, timer_out});
    // Remote bit flip refused, buffer bit still taken
    wr(`TPC_OFS_CARRIER, 8'h81);
    rd(`TPC_OFS_CARRIER, 8'h01);
    evt();
    rd(`TPC_OFS_CARRIER, 8'h03);
    chk("carrier level high", 32'h1, {31'h0, timer_out});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`TPC_OFS_MASK, 8'h04);
    clks(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`TPC_OFS_STATUS, 8'h04);
    clks(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Buffer back to low, spaced by a full bus access
    wr(`TPC_OFS_CARRIER, 8'h02);
    evt();
    rd(`TPC_OFS_CARRIER, 8'h00);
    // Remote mode: carrier level gated by the duty wave
    wr(`TPC_OFS_MODE, 8'h00);
    wr(`TPC_OFS_CARRIER, 8'h81);
    wr(`TPC_OFS_DUTY, 8'h08);
    wr(`TPC_OFS_MODE, 8'h11);
    evt();
    rd(`TPC_OFS_CARRIER, 8'h83);
    highs(17, hi);
    chk("remote highs", 32'h8, hi);
    wr(`TPC_OFS_STATUS, 8'h04);
    // Partner event in PWM mode leaves the status alone
    wr(`TPC_OFS_MODE, 8'h00);
    wr(`TPC_OFS_DUTY, 8'h08);
    wr(`TPC_OFS_MODE, 8'h01);
    evt();
    chk("irq pwm", 32'h0, {31'h0, irq});
    wr(`TPC_OFS_DUTY, 8'h04);
    clks(6);
    highs(17, hi);
    chk("pwm highs", 32'h4, hi);
    wr(`TPC_OFS_MODE, 8'h00);
    clks(4);
    chk("reads left", 32'h0, exp_q.size());
    end_sim();
  end
endmodule : tb
